// *** design/flash_susp_pkg.sv ***
// Shared constants for the flash suspend and resume controller
package flash_susp_pkg;
  // Command codes
  localparam logic [7:0] CMD_ERASE_SUSPEND = 8'h75;
  localparam logic [7:0] CMD_ERASE_RESUME = 8'h7a;
  localparam logic [7:0] CMD_PROG_SUSPEND = 8'h85;
  localparam logic [7:0] CMD_PROG_RESUME = 8'h8a;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  // Latency unit codes
  localparam logic [1:0] UNIT_128NS = 2'h0;
  localparam logic [1:0] UNIT_1US = 2'h1;
  localparam logic [1:0] UNIT_8US = 2'h2;
  localparam logic [1:0] UNIT_64US = 2'h3;
  // Advertised suspend parameter fields
  localparam logic SUSP_SUPPORTED_N = 1'b0;
  localparam logic [1:0] ERS_LAT_UNIT = UNIT_8US;
  localparam logic [4:0] ERS_LAT_COUNT = 5'h04;
  localparam logic [3:0] ERS_RES_INTERVAL = 4'h1;
  localparam logic [1:0] PGM_LAT_UNIT = UNIT_8US;
  localparam logic [4:0] PGM_LAT_COUNT = 5'h04;
  localparam logic [3:0] PGM_RES_INTERVAL = 4'h1;
  localparam logic RFU_BIT = 1'b1;
  localparam logic [3:0] ERS_PROHIBIT = 4'he;
  localparam logic [3:0] PGM_PROHIBIT = 4'hc;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SUSP_LAT_US = 40;
  // Longest time rounds down; leave a few cycles of margin for the crossing
  localparam int SUSP_LAT_CYCLES = (SUSP_LAT_US * 1000) / CLK_PERIOD_NS;
  localparam int CROSS_MARGIN = 8;
  localparam int SUSP_WORK_CYCLES = SUSP_LAT_CYCLES - CROSS_MARGIN;
endpackage

// *** design/flash_suspend_resume_control.sv ***
// Suspend and resume controller for embedded erase and page program
//
// Contract
// [RQ1] Erase suspended within 40 us of command
// [RQ2] Host waits 128 us resume to suspend
// [RQ3] Program suspended within 40 us of command
// [RQ4] Host waits 128 us program resume to suspend
// [RQ5] Latency is count plus one times unit
// [RQ6] Erase suspended: no erase, no sector access
// [RQ7] Program suspended: no erase, program, page read
// [RQ8] Code 75h suspends an erase
// [RQ9] Code 7Ah resumes a suspended erase
// [RQ10] Code 85h suspends a page program
// [RQ11] Code 8Ah resumes a suspended program
// [RQ12] Parameter bit 31 zero: suspend supported
// [RQ13] Host polls status bit 0 for busy
// [RQ14] Host times interval and suspend latency
`timescale 1ns/1ns
module flash_suspend_resume_control (
  // System clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic ARST_N_IN,
  // Link side: decoded instruction byte on the serial clock
  input wire logic LINK_CLK_IN,
  input wire logic LINK_CMD_VALID_IN,
  input wire logic [7:0] LINK_CMD_IN,
  // Array engine: start requests and completion from the core
  input wire logic ERASE_START_IN,
  input wire logic PROG_START_IN,
  input wire logic OP_DONE_IN,
  // Array engine control
  output logic ENGINE_RUN_OUT,
  // Status
  output logic BUSY_OUT,
  output logic ERASE_SUSPENDED_OUT,
  output logic PROG_SUSPENDED_OUT,
  output logic [1:0] CMD_IGNORED_OUT,
  output logic [31:0] SUSP_PARAM_OUT
);

  // Controller states
  // Stopping states hold the engine off while the array winds down
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ERASE,
    ST_ERASE_STOPPING,
    ST_ERASE_SUSP,
    ST_PROG,
    ST_PROG_STOPPING,
    ST_PROG_SUSP
  } ctl_state_t;

  // Command kinds passed over the crossing
  typedef enum logic [2:0] {
    K_NONE,
    K_ERS_SUSP,
    K_ERS_RES,
    K_PGM_SUSP,
    K_PGM_RES
  } cmd_kind_t;

  // Maps an instruction byte to a command kind
  // Bytes other than the four suspend and resume codes map to none
  function automatic cmd_kind_t decode_cmd(input logic [7:0] code);
    cmd_kind_t k;
    k = K_NONE;
    unique case (code)
      flash_susp_pkg::CMD_ERASE_SUSPEND: k = K_ERS_SUSP; // [RQ8]
      flash_susp_pkg::CMD_ERASE_RESUME: k = K_ERS_RES; // [RQ9]
      flash_susp_pkg::CMD_PROG_SUSPEND: k = K_PGM_SUSP; // [RQ10]
      flash_susp_pkg::CMD_PROG_RESUME: k = K_PGM_RES; // [RQ11]
      default: k = K_NONE;
    endcase
    return k;
  endfunction

  // Engine running: erase or program in progress, not stopping
  function automatic logic is_running(input ctl_state_t st);
    return (st == ST_ERASE || st == ST_PROG);
  endfunction

  // Winding down after an accepted suspend
  function automatic logic is_stopping(input ctl_state_t st);
    return (st == ST_ERASE_STOPPING || st == ST_PROG_STOPPING);
  endfunction

  // True once the stop phase has used its share of the latency budget
  // Compared rather than matched, so a skipped count cannot overrun
  function automatic logic stop_finished(input logic [15:0] cnt);
    return (cnt >= 16'(flash_susp_pkg::SUSP_WORK_CYCLES));
  endfunction

  // True when a command fits the state it arrives in
  // Anything else is counted and otherwise dropped
  function automatic logic cmd_fits(input ctl_state_t st, input cmd_kind_t kind);
    logic fits;
    fits = 1'b0;
    unique case (st)
      ST_ERASE: fits = (kind == K_ERS_SUSP); // [RQ8]
      ST_ERASE_SUSP: fits = (kind == K_ERS_RES); // [RQ9]
      ST_PROG: fits = (kind == K_PGM_SUSP); // [RQ10]
      ST_PROG_SUSP: fits = (kind == K_PGM_RES); // [RQ11]
      default: fits = 1'b0;
    endcase
    return fits;
  endfunction

  // Link-domain capture: kind held stable, event signalled by toggle
  // Kind is written only on the link clock; the system side reads it after the toggle
  logic [2:0] link_kind; // Held until the next command
  logic link_toggle; // Flips once per recognised command
  cmd_kind_t link_dec; // Decoded byte

  // Decode on the link side so only recognised codes cross
  always_comb begin
    link_dec = decode_cmd(LINK_CMD_IN);
  end

  // Link clock may stop between frames; nothing here waits on it
  // Unrecognised codes leave kind and toggle alone, so they never cross
  always_ff @(posedge LINK_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      link_kind <= 3'h0;
      link_toggle <= 1'b0;
    end else if (LINK_CMD_VALID_IN && link_dec != K_NONE) begin
      link_kind <= link_dec;
      link_toggle <= ~link_toggle;
    end
  end

  // Toggle synchroniser into the system domain
  // A toggle rather than a pulse, as the link clock may be faster or stopped
  // Limitation: commands need three system cycles between them
  logic tog_meta; // First stage, read only by tog_sync
  logic tog_sync; // Second stage
  logic tog_last; // Previous synced value for edge detection

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_last <= 1'b0;
    end else begin
      tog_meta <= link_toggle;
      tog_sync <= tog_meta;
      tog_last <= tog_sync;
    end
  end

  // Kind is stable for two edges before the toggle shows, so sampling is safe
  // Either edge of the synced toggle marks exactly one command
  logic cmd_event; // One-cycle pulse per command
  cmd_kind_t cmd_now; // Kind qualified by the event
  assign cmd_event = tog_sync ^ tog_last;
  assign cmd_now = cmd_event ? cmd_kind_t'(link_kind) : K_NONE;

  // Engine-side inputs come from another block on the system clock
  ctl_state_t state; // Controller state
  logic [15:0] lat_count; // Cycles spent stopping

  // Main sequencer
  // Suspends and resumes arrive only through cmd_now, one per event
  // A done that lands in a stop phase ends the operation instead of parking it
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        // Idle: an operation may start
        ST_IDLE: begin
          if (ERASE_START_IN) begin
            state <= ST_ERASE;
          end else if (PROG_START_IN) begin
            state <= ST_PROG;
          end
        end
        // Erasing: completion wins over a suspend in the same cycle
        ST_ERASE: begin
          if (OP_DONE_IN) begin
            state <= ST_IDLE;
          end else if (cmd_now == K_ERS_SUSP) begin
            state <= ST_ERASE_STOPPING; // [RQ8]
          end
        end
        // Stopping erase, bounded by the latency counter
        ST_ERASE_STOPPING: begin
          if (OP_DONE_IN) begin
            state <= ST_IDLE;
          end else if (stop_finished(lat_count)) begin
            state <= ST_ERASE_SUSP; // [RQ1]
          end
        end
        // Erase suspended; new erase starts are not honoured
        // A late done is ignored here; the array is parked
        ST_ERASE_SUSP: begin
          if (cmd_now == K_ERS_RES) begin
            state <= ST_ERASE; // [RQ9]
          end
        end
        // Programming
        ST_PROG: begin
          if (OP_DONE_IN) begin
            state <= ST_IDLE;
          end else if (cmd_now == K_PGM_SUSP) begin
            state <= ST_PROG_STOPPING; // [RQ10]
          end
        end
        // Stopping program
        ST_PROG_STOPPING: begin
          if (OP_DONE_IN) begin
            state <= ST_IDLE;
          end else if (stop_finished(lat_count)) begin
            state <= ST_PROG_SUSP; // [RQ3]
          end
        end
        // Program suspended; no erase or program nesting
        // A late done is ignored here as well
        ST_PROG_SUSP: begin
          if (cmd_now == K_PGM_RES) begin
            state <= ST_PROG; // [RQ11]
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Latency counter, runs only while stopping
  // Cleared outside the stop phase so each suspend gets the full budget
  // Sixteen bits cover the budget with room to spare
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      lat_count <= 16'h0000;
    end else if (is_stopping(state)) begin
      lat_count <= lat_count + 16'h0001; // [RQ1] [RQ3]
    end else begin
      lat_count <= 16'h0000;
    end
  end

  // Counts commands that do not fit the current state
  // Wraps at four; a debug aid rather than a status
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      CMD_IGNORED_OUT <= 2'h0;
    end else if (cmd_event) begin
      // Starts during a suspend are refused by the state machine as well
      if (!cmd_fits(state, cmd_now)) begin
        CMD_IGNORED_OUT <= CMD_IGNORED_OUT + 2'h1; // Wraps; diagnostic only
      end
    end
  end

  // Engine enable, registered so the array sees a clean level
  // Drops one system cycle after a stop phase begins
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ENGINE_RUN_OUT <= 1'b0;
    end else begin
      ENGINE_RUN_OUT <= is_running(state);
    end
  end

  // Busy bit: running or stopping
  // Clears once suspended, so status polling sees ready
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      BUSY_OUT <= 1'b0;
    end else begin
      BUSY_OUT <= is_running(state) || is_stopping(state); // [RQ13]
    end
  end

  // Suspended flags; they tell the host what it may not start
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ERASE_SUSPENDED_OUT <= 1'b0;
      PROG_SUSPENDED_OUT <= 1'b0;
    end else begin
      // Only one can be set, as the states exclude each other
      ERASE_SUSPENDED_OUT <= (state == ST_ERASE_SUSP); // [RQ1] [RQ6]
      PROG_SUSPENDED_OUT <= (state == ST_PROG_SUSP); // [RQ3] [RQ7]
    end
  end

  // Advertised suspend parameter word, a constant held in a register
  // Fields, top first: support, erase unit, count, interval,
  // program unit, count, interval, spare bit, then the two prohibit masks
  // Zero in reset, so it must not be read before the first clock
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      SUSP_PARAM_OUT <= 32'h0000_0000;
    end else begin
      SUSP_PARAM_OUT <= {flash_susp_pkg::SUSP_SUPPORTED_N, // [RQ12]
                         flash_susp_pkg::ERS_LAT_UNIT, flash_susp_pkg::ERS_LAT_COUNT, // [RQ5]
                         flash_susp_pkg::ERS_RES_INTERVAL,
                         flash_susp_pkg::PGM_LAT_UNIT, flash_susp_pkg::PGM_LAT_COUNT,
                         flash_susp_pkg::PGM_RES_INTERVAL, flash_susp_pkg::RFU_BIT,
                         flash_susp_pkg::ERS_PROHIBIT, flash_susp_pkg::PGM_PROHIBIT};
    end
  end

endmodule

// *** testbench/flash_susp_assertions.sv ***
// Port checks for the suspend controller
`timescale 1ns/1ns
module flash_susp_assertions (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic ARST_N_IN,
  // Watched outputs
  input wire logic ENGINE_RUN_OUT,
  input wire logic BUSY_OUT,
  input wire logic ERASE_SUSPENDED_OUT,
  input wire logic PROG_SUSPENDED_OUT,
  input wire logic [31:0] SUSP_PARAM_OUT
);
  // Single domain, so clock and reset are stated once
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  a_param_word: assert property ($past(ARST_N_IN) |-> SUSP_PARAM_OUT == 32'h441883ec)
    else $error("suspend parameter word wrong");
  a_support_bit: assert property (SUSP_PARAM_OUT[31] == 1'b0)
    else $error("support bit set");
  a_run_busy: assert property (ENGINE_RUN_OUT |-> BUSY_OUT)
    else $error("running but not busy");
  a_erase_quiet: assert property (ERASE_SUSPENDED_OUT |-> !BUSY_OUT && !ENGINE_RUN_OUT)
    else $error("erase suspended yet active");
  a_prog_quiet: assert property (PROG_SUSPENDED_OUT |-> !BUSY_OUT && !ENGINE_RUN_OUT)
    else $error("program suspended yet active");
  a_one_suspend: assert property (!(ERASE_SUSPENDED_OUT && PROG_SUSPENDED_OUT))
    else $error("both suspended");
  // Stopping must end inside 40 us of 8 ns cycles, counted in helper logic
  localparam logic [12:0] STOP_LIMIT = 13'h1388;
  logic [12:0] stop_len; // Cycles busy with the engine held off
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      stop_len <= 13'h0000;
    end else if (BUSY_OUT && !ENGINE_RUN_OUT) begin
      stop_len <= stop_len + 13'h0001;
    end else begin
      stop_len <= 13'h0000;
    end
  end
  a_stop_bound: assert property (stop_len <= STOP_LIMIT)
    else $error("suspend latency exceeded");
  a_erase_resume: assert property ($fell(ERASE_SUSPENDED_OUT) |-> ENGINE_RUN_OUT)
    else $error("erase resume did not run");
  a_prog_resume: assert property ($fell(PROG_SUSPENDED_OUT) |-> ENGINE_RUN_OUT)
    else $error("program resume did not run");
  c_erase_susp: cover property ($rose(ERASE_SUSPENDED_OUT));
  c_prog_susp: cover property ($rose(PROG_SUSPENDED_OUT));
  c_stopping: cover property ($fell(ENGINE_RUN_OUT) && BUSY_OUT);
endmodule
bind flash_suspend_resume_control flash_susp_assertions u_chk (.SYS_CLK_IN(SYS_CLK_IN), .ARST_N_IN(ARST_N_IN),
  .ENGINE_RUN_OUT(ENGINE_RUN_OUT), .BUSY_OUT(BUSY_OUT), .ERASE_SUSPENDED_OUT(ERASE_SUSPENDED_OUT),
  .PROG_SUSPENDED_OUT(PROG_SUSPENDED_OUT), .SUSP_PARAM_OUT(SUSP_PARAM_OUT));

// *** testbench/flash_host_model.sv ***
// Host controller model sending instruction bytes on the link
`timescale 1ns/1ns
module flash_host_model (
  output logic link_clk,
  output logic cmd_valid,
  output logic [7:0] cmd
);
  realtime last_resume = -1.0e9; // Time of last resume sent
  initial begin
    link_clk = 1'b0; // Clock stands still between frames
    cmd_valid = 1'b0;
    cmd = 8'h00;
  end
  // One frame: byte held over one link edge, then a flush edge
  task automatic send(input logic [7:0] code);
    realtime gap;
    gap = $realtime - last_resume;
    if ((code == 8'h75 || code == 8'h85) && gap < 128000.0) begin
      #(128000.0 - gap);
    end
    cmd = code;
    cmd_valid = 1'b1;
    #7 link_clk = 1'b1;
    #8 link_clk = 1'b0;
    cmd_valid = 1'b0;
    cmd = ~code; // Stale byte must not look valid
    #7 link_clk = 1'b1;
    #8 link_clk = 1'b0;
    if (code == 8'h7a || code == 8'h8a) begin
      last_resume = $realtime;
    end
  endtask
endmodule

// *** testbench/flash_suspend_resume_control_tb.sv ***
// Self-checking bench for the suspend controller
`timescale 1ns/1ns
module flash_suspend_resume_control_tb;
  logic clk, rst_n, lclk, lval, es, ps, done, run, busy, esus, psus;
  logic [7:0] lcmd;
  logic [1:0] ign;
  logic [31:0] prm;
  int n_mismatch = 0;
  int checks_done = 0;
  flash_suspend_resume_control u_dut (.SYS_CLK_IN(clk), .ARST_N_IN(rst_n), .LINK_CLK_IN(lclk),
    .LINK_CMD_VALID_IN(lval), .LINK_CMD_IN(lcmd), .ERASE_START_IN(es), .PROG_START_IN(ps),
    .OP_DONE_IN(done), .ENGINE_RUN_OUT(run), .BUSY_OUT(busy), .ERASE_SUSPENDED_OUT(esus),
    .PROG_SUSPENDED_OUT(psus), .CMD_IGNORED_OUT(ign), .SUSP_PARAM_OUT(prm));
  flash_host_model u_host (.link_clk(lclk), .cmd_valid(lval), .cmd(lcmd));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Pulse engine inputs for one cycle; each argument drives its own pin
  task automatic pulse(input logic e, input logic p, input logic d);
    es = e;
    ps = p;
    done = d;
    tick(1);
    es = 1'b0;
    ps = 1'b0;
    done = 1'b0;
    tick(2);
  endtask
  // Bounded wait for a suspended flag; 40 us is 5000 cycles
  task automatic wait_susp(input logic is_erase);
    int n = 0;
    while ((is_erase ? esus : psus) !== 1'b1 && n < 6000) begin
      tick(1);
      n++;
    end
    chk("latency_ok", 32'(n <= 5000), 32'h1);
  endtask
  task automatic t_param;
    chk("param_word", 32'h441883ec, prm);
    $display("test param done");
  endtask
  task automatic t_erase;
    pulse(1'b1, 1'b0, 1'b0);
    chk("erase_run", 32'h1, {31'h0, run});
    repeat (2) begin
      u_host.send(8'h75);
      wait_susp(1'b1);
      pulse(1'b1, 1'b0, 1'b0); // Refused while suspended
      chk("erase_nested", 32'h2, {30'h0, esus, run});
      u_host.send(8'h7a);
      tick(6);
      chk("erase_resumed", 32'h3, {29'h0, esus, run, busy});
    end
    pulse(1'b0, 1'b0, 1'b1);
    chk("erase_done", 32'h0, {30'h0, run, busy});
    $display("test erase done");
  endtask
  task automatic t_prog;
    pulse(1'b0, 1'b1, 1'b0);
    chk("prog_run", 32'h3, {30'h0, run, busy});
    u_host.send(8'h85);
    wait_susp(1'b0);
    pulse(1'b1, 1'b0, 1'b0); // Refused while suspended
    chk("prog_nested", 32'h2, {30'h0, psus, run});
    u_host.send(8'h8a);
    tick(6);
    chk("prog_resumed", 32'h3, {29'h0, psus, run, busy});
    u_host.send(8'h85);
    wait_susp(1'b0);
    u_host.send(8'h8a);
    tick(6);
    pulse(1'b0, 1'b0, 1'b1);
    chk("prog_done", 32'h0, {29'h0, psus, run, busy});
    $display("test prog done");
  endtask
  task automatic t_refuse;
    logic [1:0] base;
    base = ign;
    u_host.send(8'h7a);
    u_host.send(8'h85);
    tick(6);
    chk("ignored_count", 32'(base + 2'h2), 32'(ign));
    chk("refuse_idle", 32'h0, {29'h0, esus, psus, busy});
    $display("test refuse done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog past the four 128 us resume gaps and four 40 us stops
  initial begin
    #760000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    {rst_n, es, ps, done} = 4'h0;
    tick(3);
    rst_n = 1'b1;
    tick(2);
    t_param();
    t_erase();
    t_prog();
    t_refuse();
    finish_test();
  end
endmodule
